// File: inc/seh_regs.svh
`ifndef SEH_REGS_SVH
`define SEH_REGS_SVH
// ==========================================================
// command codes
`define SEH_CMD_STATUS_WRITE 8'h01
`define SEH_CMD_ARRAY_WRITE 8'h02
`define SEH_CMD_ARRAY_READ 8'h03
`define SEH_CMD_WRITE_DISABLE 8'h04
`define SEH_CMD_STATUS_READ 8'h05
`define SEH_CMD_WRITE_ENABLE 8'h06
`define SEH_CMD_IDENTITY_READ 8'h83
`define SEH_CMD_RESPONSE_READ 8'hF9
`define SEH_CMD_STANDBY 8'hE0
`define SEH_CMD_SLEEP 8'hE1
`define SEH_CMD_POWERDOWN 8'hE2
`define SEH_CMD_EXT_STATUS_VOL_WRITE 8'hE3
`define SEH_CMD_EXT_STATUS_PER_WRITE 8'hE4
`define SEH_CMD_AUX_CFG_VOL_WRITE 8'hE5
`define SEH_CMD_AUX_CFG_PER_WRITE 8'hE6
`define SEH_CMD_AUX_CFG_PREP_READ 8'hE7
`define SEH_CMD_WEAROUT_PREP_READ 8'hE8
`define SEH_CMD_SUPPLY_PREP_READ 8'hE9
// ==========================================================
// field widths and counts
`define SEH_SECTOR_W 3
`define SEH_OFFSET_W 16
`define SEH_SECTORS 8
`define SEH_ADDR_BYTES 2'h2
`define SEH_LAST_BIT 3'h7
`define SEH_LOC_ONE 19'h00001
`define SEH_DATA_W 8
`define SEH_FIFO_DEPTH 16
`define SEH_PINS_IDLE 4'h9
`define SEH_EMPTY_BYTE 8'hFF
`endif

// File: inc/seh_pkg.sv
`include "seh_regs.svh"
package seh_pkg;
  // ========================================================
  // carriers
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
  } seh_pins_t;

  typedef struct packed {
    logic [`SEH_SECTOR_W-1:0] sector;
    logic [`SEH_OFFSET_W-1:0] offset;
  } seh_loc_t;

  typedef enum {
    PH_CMD, PH_ADDR, PH_STREAM, PH_STATUS, PH_RESP, PH_SINK, PH_IGNORE
  } seh_phase_t;
endpackage : seh_pkg

// File: core/seh_sync.sv
`timescale 1ns/1ps
`default_nettype none
module seh_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] IDLE = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1, s2, s3, next_q;

  // a bit counts once the two later stages agree
  always_comb begin
    next_q = q;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_q[i] = s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1 <= IDLE;
      s2 <= IDLE;
      s3 <= IDLE;
      q <= IDLE;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule : seh_sync
`default_nettype wire

// File: core/seh_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module seh_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] next_mem [DEPTH];
  logic [AW-1:0] wr, rd, next_wr, next_rd;
  logic [CW-1:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data = mem[rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    next_mem = mem;
    next_wr = wr;
    next_rd = rd;
    next_count = count;
    if (push) begin
      next_mem[wr] = in_data;
      next_wr = (wr == LAST) ? '0 : wr + 1'b1;
    end
    if (pop) begin
      next_rd = (rd == LAST) ? '0 : rd + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
    // flush drops whatever a finished transaction left behind
    if (flush) begin
      next_wr = '0;
      next_rd = '0;
      next_count = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr <= '0;
      rd <= '0;
      count <= '0;
    end else begin
      wr <= next_wr;
      rd <= next_rd;
      count <= next_count;
    end
    mem <= next_mem;
  end
endmodule : seh_fifo
`default_nettype wire

// File: core/seh_core.sv
// How it works
// RULE_01: hold low floats the output and ignores clock and data edges.
// RULE_02: master keeps chip select low throughout a pause.
// RULE_03: hold released, the transaction resumes exactly where it stopped.
// RULE_04: master moves hold only while the serial clock is stable.
// RULE_05: master pauses only on a byte boundary.
// RULE_06: while an extended operation runs, only status reads are served.
// RULE_07: host polls status until the busy bit reads low.
// RULE_08: an invalid command is ignored and the output stays floating.
// RULE_09: 02h array write, 06h write enable, 04h write disable.
// RULE_10: 03h array read and 05h status read, neither extended.
// RULE_11: 83h identity read and F9h response read, neither extended.
// RULE_12: standby E0h, sleep E1h, power-down E2h are extended.
// RULE_13: 01h, E3h, E4h status writes are extended operations.
// RULE_14: E5h and E6h auxiliary configuration writes are extended.
// RULE_15: E7h, E8h, E9h prepare data for the response read, extended.
// RULE_16: array read takes a sector byte then a 16-bit offset.
// RULE_17: sector is 3 bits; master sends upper sector bits as zero.
// RULE_18: after the last address byte, stream bytes until chip select rises.
// RULE_19: the read address advances by one per byte.
// RULE_20: at a sector end, wrap within sector or continue to the next.
// RULE_21: array read or write while busy is an invalid command.
// RULE_22: array read only proceeds on a powered-up sector.
// RULE_23: sample input on rising clock, drive output on falling; modes 0, 3.
// RULE_24: whole bytes, most significant bit first on both lines.
// RULE_25: first byte after chip select falls is the command; rise ends it.
// RULE_26: chip select high floats the output and accepts no command.
// RULE_27: a pause keeps bit count, byte count, command and address.
`timescale 1ns/1ps
`default_nettype none
`include "seh_regs.svh"
module seh_core (
  input wire logic ref_clk,
  input wire logic reset,
  input wire seh_pkg::seh_pins_t pins,
  output logic so,
  output logic so_oe,
  input wire logic wrap_within_sector,
  input wire logic [`SEH_SECTORS-1:0] sector_powered,
  input wire logic [6:0] status_upper,
  input wire logic [7:0] resp_data,
  output logic mem_req,
  output var seh_pkg::seh_loc_t mem_addr,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rvalid,
  output logic cmd_strobe,
  output logic [7:0] cmd_code,
  output logic op_start,
  output logic [7:0] op_code,
  input wire logic op_done,
  output logic busy
);
  import seh_pkg::*;

  // ========================================================
  // state
  seh_phase_t phase, next_phase;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] rx_shift, next_rx_shift, tx_shift, next_tx_shift, src;
  logic [1:0] addr_cnt, next_addr_cnt;
  seh_loc_t loc, next_loc, next_mem_addr;
  logic tx_on, next_tx_on, next_so, next_so_oe;
  logic eoc_pend, next_eoc_pend, fetch_wait, next_fetch_wait;
  logic [7:0] eoc_code, next_eoc_code, next_op_code, next_cmd_code;
  logic next_op_start, next_busy, next_cmd_strobe, next_mem_req;

  // ========================================================
  // pin sampling
  logic [3:0] pins_q;
  seh_pins_t pins_s;
  logic prev_sck, prev_cs_n, sck_rise, sck_fall, cs_end, byte_done;
  logic [7:0] rx_byte;

  seh_sync #(.W(4), .IDLE(`SEH_PINS_IDLE)) u_sync (
    .clk(ref_clk),
    .reset(reset),
    .d(pins),
    .q(pins_q)
  );
  assign pins_s = seh_pins_t'(pins_q);

  // RULE_01 edges dropped in pause
  assign sck_rise = !pins_s.cs_n & pins_s.hold_n & pins_s.sck & !prev_sck;
  assign sck_fall = !pins_s.cs_n & pins_s.hold_n & !pins_s.sck & prev_sck;
  // RULE_25 rising select ends
  assign cs_end = pins_s.cs_n & !prev_cs_n;
  assign rx_byte = {rx_shift[6:0], pins_s.si};
  assign byte_done = sck_rise && (bit_cnt == `SEH_LAST_BIT);

  // ========================================================
  // read prefetch buffer
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [7:0] fifo_out_data;

  // a stalled buffer holds back fetches, so memory never outruns the link
  seh_fifo #(.W(`SEH_DATA_W), .DEPTH(`SEH_FIFO_DEPTH)) u_fifo (
    .clk(ref_clk),
    .reset(reset),
    .flush(cs_end),
    .in_valid(mem_rvalid & fetch_wait),
    .in_ready(fifo_in_ready),
    .in_data(mem_rdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // ========================================================
  // transaction state

  function automatic logic is_eoc(input logic [7:0] c);
    return c inside {`SEH_CMD_STATUS_WRITE, `SEH_CMD_ARRAY_WRITE,
      `SEH_CMD_STANDBY, `SEH_CMD_SLEEP, `SEH_CMD_POWERDOWN,
      `SEH_CMD_EXT_STATUS_VOL_WRITE, `SEH_CMD_EXT_STATUS_PER_WRITE,
      `SEH_CMD_AUX_CFG_VOL_WRITE, `SEH_CMD_AUX_CFG_PER_WRITE,
      `SEH_CMD_AUX_CFG_PREP_READ, `SEH_CMD_WEAROUT_PREP_READ,
      `SEH_CMD_SUPPLY_PREP_READ};
  endfunction : is_eoc

  function automatic seh_loc_t loc_inc(input seh_loc_t l, input logic wrap);
    seh_loc_t r;
    r = l;
    if (wrap) begin
      r.offset = l.offset + 1'b1;
    end else begin
      r = seh_loc_t'(l + `SEH_LOC_ONE);
    end
    return r;
  endfunction : loc_inc

  always_comb begin
    next_phase = phase;
    next_bit_cnt = bit_cnt;
    next_rx_shift = rx_shift;
    next_tx_shift = tx_shift;
    next_addr_cnt = addr_cnt;
    next_loc = loc;
    next_tx_on = tx_on;
    next_so = so;
    next_eoc_pend = eoc_pend;
    next_eoc_code = eoc_code;
    next_op_code = op_code;
    next_cmd_code = cmd_code;
    next_op_start = 1'b0;
    next_cmd_strobe = 1'b0;
    next_mem_req = 1'b0;
    next_mem_addr = mem_addr;
    next_fetch_wait = fetch_wait & !mem_rvalid;
    next_busy = busy & !op_done;
    fifo_pop = 1'b0;
    src = `SEH_EMPTY_BYTE;
    // RULE_19 fetch address advances
    // RULE_20 wrap mode
    if (phase == PH_STREAM && !fetch_wait && fifo_in_ready) begin
      next_mem_req = 1'b1;
      next_mem_addr = loc;
      next_loc = loc_inc(loc, wrap_within_sector);
      next_fetch_wait = 1'b1;
    end
    // RULE_23 sample on rise
    // RULE_24 msb first in
    if (sck_rise) begin
      next_rx_shift = rx_byte;
      next_bit_cnt = bit_cnt + 1'b1;
    end
    if (byte_done) begin
      unique case (phase)
        PH_CMD: begin
          // RULE_06 busy serves status only
          // RULE_21 busy read/write invalid
          if (busy && rx_byte != `SEH_CMD_STATUS_READ) begin
            next_phase = PH_IGNORE;
          end else begin
            // RULE_08 invalid code ignored
            unique case (rx_byte)
              // RULE_10 read and status
              `SEH_CMD_ARRAY_READ: begin
                next_phase = PH_ADDR;
                next_addr_cnt = '0;
              end
              `SEH_CMD_STATUS_READ: next_phase = PH_STATUS;
              // RULE_11 identity and response
              `SEH_CMD_IDENTITY_READ, `SEH_CMD_RESPONSE_READ: next_phase = PH_RESP;
              // RULE_09 enable and disable
              `SEH_CMD_WRITE_ENABLE, `SEH_CMD_WRITE_DISABLE: begin
                next_cmd_strobe = 1'b1;
                next_cmd_code = rx_byte;
                next_phase = PH_SINK;
              end
              default: begin
                // RULE_12 power commands extended
                // RULE_13 status writes extended
                // RULE_14 aux writes extended
                // RULE_15 prepare reads extended
                if (is_eoc(rx_byte)) begin
                  next_eoc_pend = 1'b1;
                  next_eoc_code = rx_byte;
                  next_phase = PH_SINK;
                end else begin
                  next_phase = PH_IGNORE;
                end
              end
            endcase
          end
        end
        PH_ADDR: begin
          // RULE_16 capture location bytes
          next_addr_cnt = addr_cnt + 1'b1;
          unique case (addr_cnt)
            // RULE_17 three sector bits
            2'h0: next_loc.sector = rx_byte[`SEH_SECTOR_W-1:0];
            2'h1: next_loc.offset[15:8] = rx_byte;
            default: begin
              next_loc.offset[7:0] = rx_byte;
              // RULE_22 powered sector only
              next_phase = sector_powered[loc.sector] ? PH_STREAM : PH_IGNORE;
            end
          endcase
        end
        default: begin
        end
      endcase
    end
    // RULE_23 drive on fall
    // RULE_18 stream after address
    if (sck_fall) begin
      if (bit_cnt == '0 && phase inside {PH_STATUS, PH_RESP, PH_STREAM}) begin
        unique case (phase)
          // RULE_07 busy in bit zero
          PH_STATUS: src = {status_upper, busy};
          PH_RESP: src = resp_data;
          default: begin
            src = fifo_out_valid ? fifo_out_data : `SEH_EMPTY_BYTE;
            fifo_pop = fifo_out_valid;
          end
        endcase
        next_so = src[7];
        next_tx_shift = {src[6:0], 1'b0};
        next_tx_on = 1'b1;
      end else if (tx_on) begin
        // RULE_24 msb first out
        next_so = tx_shift[7];
        next_tx_shift = {tx_shift[6:0], 1'b0};
      end
    end
    // RULE_25 rise ends operation
    if (cs_end) begin
      next_phase = PH_CMD;
      next_bit_cnt = '0;
      next_tx_on = 1'b0;
      next_eoc_pend = 1'b0;
      next_fetch_wait = 1'b0;
      next_mem_req = 1'b0;
      // RULE_06 extended op starts busy
      if (eoc_pend) begin
        next_op_start = 1'b1;
        next_op_code = eoc_code;
        next_busy = 1'b1;
      end
    end
    // RULE_01 float in pause
    // RULE_26 float when deselected
    // RULE_03 resumes with held state
    next_so_oe = !pins_s.cs_n & pins_s.hold_n & next_tx_on;
  end

  // RULE_27 state kept in pause
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prev_sck <= 1'b0;
      prev_cs_n <= 1'b1;
      phase <= PH_CMD;
      bit_cnt <= '0;
      rx_shift <= '0;
      tx_shift <= '0;
      addr_cnt <= '0;
      loc <= '0;
      tx_on <= 1'b0;
      so <= 1'b0;
      so_oe <= 1'b0;
      eoc_pend <= 1'b0;
      eoc_code <= '0;
      op_start <= 1'b0;
      op_code <= '0;
      cmd_strobe <= 1'b0;
      cmd_code <= '0;
      busy <= 1'b0;
      mem_req <= 1'b0;
      mem_addr <= '0;
      fetch_wait <= 1'b0;
    end else begin
      prev_sck <= pins_s.sck;
      prev_cs_n <= pins_s.cs_n;
      phase <= next_phase;
      bit_cnt <= next_bit_cnt;
      rx_shift <= next_rx_shift;
      tx_shift <= next_tx_shift;
      addr_cnt <= next_addr_cnt;
      loc <= next_loc;
      tx_on <= next_tx_on;
      so <= next_so;
      so_oe <= next_so_oe;
      eoc_pend <= next_eoc_pend;
      eoc_code <= next_eoc_code;
      op_start <= next_op_start;
      op_code <= next_op_code;
      cmd_strobe <= next_cmd_strobe;
      cmd_code <= next_cmd_code;
      busy <= next_busy;
      mem_req <= next_mem_req;
      mem_addr <= next_mem_addr;
      fetch_wait <= next_fetch_wait;
    end
  end

  // ========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_eoc_end;
    cs_end && eoc_pend;
  endsequence

  sequence s_last_addr;
    byte_done && phase == PH_ADDR && addr_cnt == `SEH_ADDR_BYTES;
  endsequence

  a_hold_floats: assert property (!pins_s.hold_n |=> !so_oe) // RULE_01
    else $error("output driven during pause");
  a_pause_keeps: assert property (!pins_s.hold_n && !pins_s.cs_n |=> // RULE_27
    $stable(bit_cnt) && $stable(phase) && ($stable(loc) || mem_req))
    else $error("state moved during pause");
  a_desel_quiet: assert property (pins_s.cs_n |=> !so_oe && phase == PH_CMD) // RULE_26
    else $error("deselected device active");
  a_busy_refuses: assert property (byte_done && phase == PH_CMD && busy && // RULE_06
    rx_byte != `SEH_CMD_STATUS_READ |=> phase == PH_IGNORE)
    else $error("command served while busy");
  a_invalid_quiet: assert property (phase == PH_IGNORE |-> !so_oe && !tx_on) // RULE_08
    else $error("output driven after invalid command");
  a_eoc_start: assert property (s_eoc_end |=> op_start && busy ##1 !op_start) // RULE_12
    else $error("extended operation not started");
  a_read_enter: assert property (s_last_addr |=> // RULE_22
    phase == (sector_powered[$past(loc.sector)] ? PH_STREAM : PH_IGNORE))
    else $error("wrong phase after address");
  a_fetch_wrap: assert property (mem_req && wrap_within_sector && // RULE_20
    phase == PH_STREAM |-> loc.sector == mem_addr.sector)
    else $error("sector wrap crossed sector");
  a_fetch_step: assert property (mem_req |-> // RULE_19
    loc == loc_inc(mem_addr, $past(wrap_within_sector)))
    else $error("read address did not advance by one");
endmodule : seh_core
`default_nettype wire

// File: sim/seh_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "seh_regs.svh"
module seh_spi_master (
  input wire logic ref_clk,
  input wire logic so_line,
  output var seh_pkg::seh_pins_t pins
);
  import seh_pkg::*;
  logic [7:0] last;
  logic mode3 = 1'b0;
  event got;
  initial begin
    pins = `SEH_PINS_IDLE;
  end
  // ==========
  // link timing, half an sck period is 4 ref_clk
  task automatic half;
    repeat (4) @(negedge ref_clk);
  endtask : half
  task automatic select(input logic on);
    // clock settles at its idle level before the frame opens
    if (on) begin
      pins.sck = mode3;
    end
    half();
    pins.cs_n = ~on;
    half();
  endtask : select
  // msb first, mode 0 or 3
  task automatic xfer(input logic [7:0] tx, input logic watch);
    for (int i = 7; i >= 0; i--) begin
      if (mode3) begin
        pins.sck = 1'b0;
      end
      pins.si = tx[i];
      half();
      pins.sck = 1'b1;
      half();
      // sampled late in the high phase, where the slow output has settled
      last[i] = so_line;
      if (!mode3) begin
        pins.sck = 1'b0;
      end
    end
    if (watch) begin
      ->got;
    end
  endtask : xfer
  // pause at a byte end, clock low in mode 0 and high in mode 3
  task automatic pause;
    half();
    pins.hold_n = 1'b0;
    half();
    // stray edges, as from traffic to another slave
    repeat (3) begin
      pins.sck = ~pins.sck;
      pins.si = ~pins.si;
      half();
      pins.sck = ~pins.sck;
      half();
    end
    pins.hold_n = 1'b1;
    half();
  endtask : pause
endmodule : seh_spi_master
`default_nettype wire

// File: sim/seh_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "seh_regs.svh"
module seh_core_tb;
  import seh_pkg::*;
  logic ref_clk, reset, so, so_oe, so_line, wrap_within_sector, mem_req, mem_rvalid;
  logic cmd_strobe, op_start, op_done, busy, oe_seen, hold_drive;
  logic [7:0] sector_powered, resp_data, mem_rdata, cmd_code, op_code;
  logic [6:0] status_upper;
  logic [2:0] sec;
  seh_pins_t pins;
  seh_loc_t mem_addr;
  logic [7:0] expq[$];
  logic [7:0] eoc[12] = '{8'h01, 8'h02, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6,
                          8'hE7, 8'hE8, 8'hE9};
  logic [7:0] bad[3] = '{8'h00, 8'h07, 8'hFF};
  int fails, checks, seed;
  int hold_cnt = 0;
  int req_cnt = 0;
  // ==========
  // design, link master
  seh_core seh_core_i (.ref_clk(ref_clk), .reset(reset), .pins(pins), .so(so), .so_oe(so_oe),
    .wrap_within_sector(wrap_within_sector), .sector_powered(sector_powered),
    .status_upper(status_upper), .resp_data(resp_data), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
    .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .op_start(op_start), .op_code(op_code),
    .op_done(op_done), .busy(busy));
  seh_spi_master seh_spi_master_i (.ref_clk(ref_clk), .so_line(so_line), .pins(pins));
  // pull-up on the shared output line
  assign so_line = so_oe ? so : 1'b1;
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ==========
  // array contents and responder
  function automatic logic [7:0] mem_fn(input seh_loc_t a);
    return a.offset[7:0] ^ a.offset[15:8] ^ {5'h00, a.sector};
  endfunction : mem_fn
  function automatic seh_loc_t loc_at(input logic [2:0] s, input logic [15:0] off, input int i);
    return wrap_within_sector ? {s, off + i[15:0]} : {s, off} + i[18:0];
  endfunction : loc_at
  always @(negedge ref_clk) begin
    mem_rvalid <= mem_req;
    mem_rdata <= mem_fn(mem_addr);
    hold_cnt <= pins.hold_n ? 0 : hold_cnt + 1;
    if (so_oe === 1'b1) begin
      oe_seen <= 1'b1;
      hold_drive <= hold_drive | (hold_cnt > 6);
    end
  end
  // ==========
  // checking
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic take(input logic [7:0] seen);
    // a result nobody announced must not match
    if (expq.size() == 0) begin
      expq.push_back(8'hXX);
    end
    check(seen, expq.pop_front());
  endtask : take
  always @(posedge ref_clk) begin
    if (cmd_strobe === 1'b1) begin
      take(cmd_code);
    end
    if (op_start === 1'b1) begin
      take(op_code);
    end
    if (mem_req === 1'b1) begin
      req_cnt <= req_cnt + 1;
    end
  end
  always @(seh_spi_master_i.got) begin
    take(seh_spi_master_i.last);
  end
  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  // ==========
  // frames
  task automatic rd(input logic [7:0] code, input logic [7:0] exp, input logic data);
    seh_spi_master_i.select(1'b1);
    oe_seen = 1'b0;
    seh_spi_master_i.xfer(code, 1'b0);
    if (data) begin
      expq.push_back(exp);
      seh_spi_master_i.xfer(8'h00, 1'b1);
    end
    seh_spi_master_i.select(1'b0);
  endtask : rd
  task automatic read_frame(input logic [2:0] s, input logic [15:0] off, input int cnt,
                            input int hold_at, input logic ok);
    seh_loc_t a;
    int base, last_i;
    base = req_cnt;
    // a full buffer at close holds sixteen bytes beyond those popped
    last_i = cnt + (seh_spi_master_i.mode3 ? 15 : 16);
    seh_spi_master_i.select(1'b1);
    oe_seen = 1'b0;
    seh_spi_master_i.xfer(`SEH_CMD_ARRAY_READ, 1'b0);
    // sector byte with zero upper bits, then offset
    seh_spi_master_i.xfer({5'h00, s}, 1'b0);
    seh_spi_master_i.xfer(off[15:8], 1'b0);
    seh_spi_master_i.xfer(off[7:0], 1'b0);
    for (int i = 0; i < cnt; i++) begin
      expq.push_back(ok ? mem_fn(loc_at(s, off, i)) : 8'hFF);
      if (i == hold_at) begin
        seh_spi_master_i.pause();
      end
      seh_spi_master_i.xfer(8'h00, 1'b1);
    end
    seh_spi_master_i.select(1'b0);
    check({7'h00, oe_seen}, {7'h00, ok});
    check(8'(req_cnt - base), ok ? 8'(last_i + 1) : 8'h00);
    if (ok) begin
      a = loc_at(s, off, last_i);
      check(mem_addr.offset[7:0], a.offset[7:0]);
      check({5'h00, mem_addr.sector}, {5'h00, a.sector});
    end
  endtask : read_frame
  // ==========
  // sequence
  initial begin
    seed = 38839;
    fails = 0;
    checks = 0;
    reset = 1'b1;
    {wrap_within_sector, op_done, oe_seen, hold_drive} = '0;
    sector_powered = 8'hFF;
    status_upper = 7'($random(seed));
    resp_data = 8'($random(seed));
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    // both wrap settings across a sector end, paused mid stream
    for (int m = 0; m < 2; m++) begin
      wrap_within_sector = m[0];
      sec = m[0] ? 3'($random(seed)) : 3'h7;
      read_frame(sec, 16'hFFFE, 4, 2, 1'b1);
    end
    check({7'h00, hold_drive}, 8'h00);
    sector_powered[sec] = 1'b0;
    read_frame(sec, 16'($random(seed)), 2, 9, 1'b0);
    sector_powered = 8'hFF;
    $display("array read test done");
    rd(`SEH_CMD_IDENTITY_READ, resp_data, 1'b1);
    rd(`SEH_CMD_RESPONSE_READ, resp_data, 1'b1);
    rd(`SEH_CMD_STATUS_READ, {status_upper, 1'b0}, 1'b1);
    expq.push_back(`SEH_CMD_WRITE_ENABLE);
    rd(`SEH_CMD_WRITE_ENABLE, 8'h00, 1'b0);
    expq.push_back(`SEH_CMD_WRITE_DISABLE);
    rd(`SEH_CMD_WRITE_DISABLE, 8'h00, 1'b0);
    foreach (bad[k]) begin
      rd(bad[k], 8'hFF, 1'b1);
      check({7'h00, oe_seen}, 8'h00);
    end
    $display("command decode test done");
    foreach (eoc[k]) begin
      expq.push_back(eoc[k]);
      rd(eoc[k], 8'h00, 1'b0);
      rd(`SEH_CMD_STATUS_READ, {status_upper, 1'b1}, 1'b1);
      check({7'h00, busy}, 8'h01);
      if (k == 0) begin
        read_frame(3'h0, 16'h0000, 1, 9, 1'b0);
        rd(`SEH_CMD_WRITE_ENABLE, 8'h00, 1'b0);
        rd(`SEH_CMD_IDENTITY_READ, 8'hFF, 1'b1);
        check({7'h00, oe_seen}, 8'h00);
      end
      @(negedge ref_clk);
      op_done = 1'b1;
      @(negedge ref_clk);
      op_done = 1'b0;
      rd(`SEH_CMD_STATUS_READ, {status_upper, 1'b0}, 1'b1);
    end
    $display("extended operation test done");
    // clock idles high; 20 bytes overrun the 16 deep prefetch buffer
    seh_spi_master_i.mode3 = 1'b1;
    wrap_within_sector = 1'b1;
    read_frame(3'($random(seed)), 16'($random(seed)), 20, 0, 1'b1);
    rd(`SEH_CMD_STATUS_READ, {status_upper, 1'b0}, 1'b1);
    $display("buffer test done");
    check(8'(expq.size()), 8'h00);
    complete_run();
  end
endmodule : seh_core_tb
`default_nettype wire
